// [umc_check_log.sv]
// Uncore machine-check logging, signalling, line disable and core disable.
// Assumes error sources on the same clock and a word-indexed register port.
//
// Summary of operation
// - Uncorrected tag error: bit 0, code 0x0002 internal
// - Uncorrected core-valid error: bit 1, code 0x0011
// - Corrected codes 0x0100, 0x0101, 0x0111 logged
// - Spare directory bank logs in register space
// - Memory controller has seven 32-bit error registers
// - Retry event after set retries, before retraining
// - Training failure on train fail or retrained fail
// - Agent valid bits captured in pending register
// - Pending and mask set sends redirected interrupt
// - Array bit errors raise machine-check events
// - Disabled set and way never allocated
// - Line disables persist, reapplied before cache enable
// - Reset packets deliver line disables to units
// - Masked cores are not enumerated after reboot
// - No ring cache allocation for disabled core
`timescale 1ns/1ps
`default_nettype none
module umc_check_log #(
  parameter int DIR_BANKS   = 2,
  parameter int NUM_EXT     = 4,
  parameter int NUM_CORES   = 8,
  parameter int RETRY_LIMIT = 4,
  parameter int LD_DEPTH    = 16
) (
  input  wire logic                                   SYS_CLK,
  input  wire logic                                   RST,
  input  wire logic                                   REG_WR,
  input  wire logic                                   REG_RD,
  input  wire logic [4:0]                             REG_ADDR,
  input  wire logic [31:0]                            REG_WDATA,
  output logic      [31:0]                            REG_RDATA,
  input  wire umc_pkg::umc_dir_err_t [DIR_BANKS-1:0]  DIR_ERR,
  input  wire logic                                   MC_CRC_FAIL,
  input  wire logic                                   MC_TRAIN_FAIL,
  input  wire logic                                   MC_TRAIN_DONE,
  input  wire logic                                   MC_TXN_DONE,
  input  wire logic [63:0]                            MC_TXN_ADDR,
  output logic                                        MC_RETRAIN,
  input  wire logic [NUM_EXT-1:0]                     AGENT_VALID,
  output umc_pkg::umc_irq_t                           IRQ,
  input  wire logic [NUM_CORES-1:0]                   CORE_MASK,
  output logic      [NUM_CORES-1:0]                   CORE_VISIBLE,
  output logic      [NUM_CORES-1:0]                   RING_ALLOC_EN,
  input  wire logic                                   ALLOC_REQ,
  input  wire logic [11:0]                            ALLOC_SET,
  input  wire logic [3:0]                             ALLOC_WAY,
  output logic                                        ALLOC_GRANT,
  output umc_pkg::umc_ld_t                            PKT,
  output logic                                        CACHE_EN
);

  localparam int NA = DIR_BANKS + 1 + NUM_EXT;
  localparam int IW = $clog2(LD_DEPTH);

  // Parameter limits the logic can serve
  if (DIR_BANKS < 1 || DIR_BANKS > 3 || NA > 32 || RETRY_LIMIT < 1 ||
      RETRY_LIMIT > 255 || LD_DEPTH < 2 || LD_DEPTH > 16 ||
      NUM_CORES > 32) begin : g_bad_params
    $error("umc_check_log: unsupported parameter values");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Index of a directory bank status (a=0) or address (a=1) register
  function automatic logic [4:0] dir_idx(input int b, input logic a);
    return umc_pkg::RI_DIR0_STAT + 5'(2 * b) + {4'h0, a};
  endfunction : dir_idx

  // Register write strobe for one index
  function automatic logic wr_hit(input logic [4:0] idx);
    return REG_WR && (REG_ADDR == idx);
  endfunction : wr_hit

  // Model code of a directory error
  function automatic logic [15:0] dir_code(input umc_pkg::umc_dir_err_t e);
    logic [15:0] c;
    if (e.uncorr) begin
      if (e.core_valid) begin
        c = e.internal ? umc_pkg::DC_CV_UC_INT : umc_pkg::DC_CV_UC_EXT;
      end else begin
        c = e.internal ? umc_pkg::DC_TS_UC_INT : umc_pkg::DC_TS_UC_EXT;
      end
    end else begin
      if (e.core_valid) begin
        c = e.internal ? umc_pkg::DC_CV_C_INT : umc_pkg::DC_CV_C_EXT;
      end else begin
        c = e.internal ? umc_pkg::DC_TS_C_INT : umc_pkg::DC_TS_C_EXT;
      end
    end
    return c;
  endfunction : dir_code

  ////////////////////////////////////////////////////////////////////////////
  // Memory controller error registers

  logic [31:0] mc_control_low;
  logic [31:0] mc_control_high;
  logic [31:0] mc_status_low;
  logic [31:0] mc_status_high;
  logic [31:0] mc_address_low;
  logic [31:0] mc_address_high;
  logic [31:0] transaction_timeout;
  logic [7:0]  retry_cnt;
  logic        retry_evt;
  logic        train_evt;
  logic        mc_log;
  logic        mc_busy;

  // Plain control registers
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      mc_control_low      <= '0;
      mc_control_high     <= '0;
      transaction_timeout <= '0;
    end else begin
      if (wr_hit(umc_pkg::RI_MC_CTL_LO)) mc_control_low <= REG_WDATA;
      if (wr_hit(umc_pkg::RI_MC_CTL_HI)) mc_control_high <= REG_WDATA;
      if (wr_hit(umc_pkg::RI_MC_MISC)) transaction_timeout <= REG_WDATA;
    end
  end

  // Retry and training failure detection
  assign retry_evt = MC_CRC_FAIL && !MC_RETRAIN &&
                     (retry_cnt == 8'(RETRY_LIMIT - 1));
  assign train_evt = MC_TRAIN_FAIL || (MC_CRC_FAIL && MC_RETRAIN);

  // Retry count per transaction and retraining state
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      retry_cnt  <= '0;
      MC_RETRAIN <= 1'b0;
    end else begin
      if (retry_evt || MC_TXN_DONE) begin
        retry_cnt <= '0;
      end else if (MC_CRC_FAIL && !MC_RETRAIN) begin
        retry_cnt <= retry_cnt + 8'h01;
      end
      if (retry_evt) begin
        MC_RETRAIN <= 1'b1;
      end else if (MC_TRAIN_DONE) begin
        MC_RETRAIN <= 1'b0;
      end
    end
  end

  // Logging; an event wins over a software write in the same cycle
  assign mc_log  = (retry_evt && mc_control_low[umc_pkg::CTL_RETRY]) ||
                   (train_evt && mc_control_low[umc_pkg::CTL_TRAIN_FAIL]);
  assign mc_busy = mc_status_high[umc_pkg::ST_VALID] &&
                   !wr_hit(umc_pkg::RI_MC_STAT_HI);
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      mc_status_low   <= '0;
      mc_status_high  <= '0;
      mc_address_low  <= '0;
      mc_address_high <= '0;
    end else if (mc_log && mc_busy) begin
      mc_status_high[umc_pkg::ST_OVER] <= 1'b1;
    end else if (mc_log) begin
      mc_status_low   <= train_evt ? umc_pkg::MC_CODE_TRAIN
                                   : umc_pkg::MC_CODE_RETRY;
      mc_status_high  <= '0;
      mc_status_high[umc_pkg::ST_VALID]  <= 1'b1;
      mc_status_high[umc_pkg::ST_UNCORR] <= train_evt;
      mc_address_low  <= MC_TXN_ADDR[31:0];
      mc_address_high <= MC_TXN_ADDR[63:32];
    end else begin
      if (wr_hit(umc_pkg::RI_MC_STAT_LO)) mc_status_low <= REG_WDATA;
      if (wr_hit(umc_pkg::RI_MC_STAT_HI)) mc_status_high <= REG_WDATA;
      if (wr_hit(umc_pkg::RI_MC_ADDR_LO)) mc_address_low <= REG_WDATA;
      if (wr_hit(umc_pkg::RI_MC_ADDR_HI)) mc_address_high <= REG_WDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Directory banks; the last bank is the spare one, all in register space

  logic [31:0]          error_report_control;
  logic [31:0]          directory_error_status  [DIR_BANKS];
  logic [31:0]          directory_error_address [DIR_BANKS];
  logic [DIR_BANKS-1:0] dir_valid;

  // Directory control register
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      error_report_control <= '0;
    end else if (wr_hit(umc_pkg::RI_DIR_CTL)) begin
      error_report_control <= REG_WDATA;
    end
  end

  for (genvar b = 0; b < DIR_BANKS; b++) begin : g_dir
    logic ev;
    logic busy;
    // Event enabled by the tag-state or core-valid control bit
    assign ev = DIR_ERR[b].valid &&
                error_report_control[DIR_ERR[b].core_valid ?
                  umc_pkg::CTL_CORE_VALID : umc_pkg::CTL_TAG_STATE];
    assign busy = directory_error_status[b][umc_pkg::ST_VALID] &&
                  !wr_hit(dir_idx(b, 1'b0));
    assign dir_valid[b] = directory_error_status[b][umc_pkg::ST_VALID];

    // Status and address log of this bank
    always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
        directory_error_status[b]  <= '0;
        directory_error_address[b] <= '0;
      end else if (ev && busy) begin
        directory_error_status[b][umc_pkg::ST_OVER] <= 1'b1;
      end else if (ev) begin
        directory_error_status[b] <= '0;
        directory_error_status[b][15:0] <= dir_code(DIR_ERR[b]);
        directory_error_status[b][umc_pkg::ST_VALID]  <= 1'b1;
        directory_error_status[b][umc_pkg::ST_UNCORR] <= DIR_ERR[b].uncorr;
        directory_error_address[b] <= DIR_ERR[b].addr;
      end else begin
        if (wr_hit(dir_idx(b, 1'b0))) directory_error_status[b] <= REG_WDATA;
        if (wr_hit(dir_idx(b, 1'b1))) directory_error_address[b] <= REG_WDATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt controller

  logic [NA-1:0] check_interrupt_pending;
  logic [NA-1:0] check_interrupt_mask;
  logic [15:0]   redirect;

  // Capture valid bits, mask and redirection, and raise the interrupt
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      check_interrupt_pending <= '0;
      check_interrupt_mask    <= '0;
      redirect                <= '0;
      IRQ                     <= '0;
    end else begin
      check_interrupt_pending <= {AGENT_VALID,
        mc_status_high[umc_pkg::ST_VALID], dir_valid};
      if (wr_hit(umc_pkg::RI_MASK)) check_interrupt_mask <= REG_WDATA[NA-1:0];
      if (wr_hit(umc_pkg::RI_REDIR)) redirect <= REG_WDATA[15:0];
      IRQ.valid  <= |(check_interrupt_pending & check_interrupt_mask);
      IRQ.core   <= redirect[umc_pkg::REDIR_CORE_LSB +: 8];
      IRQ.vector <= redirect[umc_pkg::REDIR_VEC_LSB +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line disable store and reset-time replay

  typedef enum logic [1:0] { ST_REPLAY, ST_DRAIN, ST_RUN } umc_state_t;
  umc_state_t       state;
  logic [IW-1:0]    rd_idx;
  logic             rd_pend;
  umc_pkg::umc_ld_t ld_q;
  umc_pkg::umc_ld_t line_disable;

  umc_line_mem #(
    .W     (umc_pkg::LD_W),
    .DEPTH (LD_DEPTH)
  ) u_mem (
    .SYS_CLK (SYS_CLK),
    .RST     (RST),
    .wr_en   (wr_hit(umc_pkg::RI_LD_WRITE)),
    .wr_addr (REG_WDATA[umc_pkg::LD_IDX_LSB +: IW]),
    .wr_data (REG_WDATA[umc_pkg::LD_W-1:0]),
    .rd_en   (state == ST_REPLAY),
    .rd_addr (rd_idx),
    .rd_data (ld_q)
  );

  // Walk every entry after reset, then enable the caches
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state    <= ST_REPLAY;
      rd_idx   <= '0;
      rd_pend  <= 1'b0;
      CACHE_EN <= 1'b0;
    end else begin
      rd_pend <= (state == ST_REPLAY);
      case (state)
        ST_REPLAY: begin
          rd_idx <= rd_idx + IW'(1);
          if (rd_idx == IW'(LD_DEPTH - 1)) state <= ST_DRAIN;
        end
        ST_DRAIN: begin
          state    <= ST_RUN;
          CACHE_EN <= 1'b1;
        end
        ST_RUN:  state <= ST_RUN;
        default: state <= ST_REPLAY;
      endcase
    end
  end

  // Reset packet for each stored entry whose valid bit is set
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PKT <= '0;
    end else begin
      PKT <= (rd_pend && ld_q.valid) ? ld_q : '0;
    end
  end

  // Directory's own line disable, set by software or by replay
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      line_disable <= '0;
    end else if (wr_hit(umc_pkg::RI_LD_DIR)) begin
      line_disable <= REG_WDATA[umc_pkg::LD_W-1:0];
    end else if (rd_pend && ld_q.valid && ld_q.unit == umc_pkg::DIR_UNIT) begin
      line_disable <= ld_q;
    end
  end

  // Allocation gate against the disabled set and way
  assign ALLOC_GRANT = ALLOC_REQ && CACHE_EN &&
    !(line_disable.valid && line_disable.set == ALLOC_SET &&
      line_disable.way == ALLOC_WAY);

  ////////////////////////////////////////////////////////////////////////////
  // Core disable

  logic [NUM_CORES-1:0] core_off;
  logic                 strap_done;

  // Catch the flash mask once after reset release
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      core_off   <= '0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      core_off   <= CORE_MASK;
      strap_done <= 1'b1;
    end
  end

  assign CORE_VISIBLE  = ~core_off & {NUM_CORES{strap_done}};
  // Co-located directory banks keep running; only the ring cache stops
  assign RING_ALLOC_EN = CORE_VISIBLE & {NUM_CORES{CACHE_EN}};

  ////////////////////////////////////////////////////////////////////////////
  // Register read

  logic [31:0] rd_mux;

  // Read multiplexer; unmapped indices read zero
  always_comb begin
    rd_mux = '0;
    case (REG_ADDR)
      umc_pkg::RI_MC_CTL_LO:  rd_mux = mc_control_low;
      umc_pkg::RI_MC_CTL_HI:  rd_mux = mc_control_high;
      umc_pkg::RI_MC_STAT_LO: rd_mux = mc_status_low;
      umc_pkg::RI_MC_STAT_HI: rd_mux = mc_status_high;
      umc_pkg::RI_MC_ADDR_LO: rd_mux = mc_address_low;
      umc_pkg::RI_MC_ADDR_HI: rd_mux = mc_address_high;
      umc_pkg::RI_MC_MISC:    rd_mux = transaction_timeout;
      umc_pkg::RI_DIR_CTL:    rd_mux = error_report_control;
      umc_pkg::RI_PEND:       rd_mux = 32'(check_interrupt_pending);
      umc_pkg::RI_MASK:       rd_mux = 32'(check_interrupt_mask);
      umc_pkg::RI_REDIR:      rd_mux = {16'h0000, redirect};
      umc_pkg::RI_LD_DIR:     rd_mux = 32'(line_disable);
      umc_pkg::RI_SYS_STAT: begin
        rd_mux[umc_pkg::SS_CACHE_EN] = CACHE_EN;
        rd_mux[umc_pkg::SS_RETRAIN]  = MC_RETRAIN;
        rd_mux[umc_pkg::SS_CNT_LSB +: 8] = retry_cnt;
      end
      default: rd_mux = '0;
    endcase
    for (int b = 0; b < DIR_BANKS; b++) begin
      if (REG_ADDR == dir_idx(b, 1'b0)) rd_mux = directory_error_status[b];
      if (REG_ADDR == dir_idx(b, 1'b1)) rd_mux = directory_error_address[b];
    end
  end

  // Read data register
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= '0;
    end else if (REG_RD) begin
      REG_RDATA <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_dir_tag_code: assert property (@(posedge SYS_CLK) disable iff (RST)
    (DIR_ERR[0].valid && DIR_ERR[0].uncorr && !DIR_ERR[0].core_valid &&
     DIR_ERR[0].internal && error_report_control[0] && !dir_valid[0])
    |=> directory_error_status[0][15:0] == 16'h0002)
    else $error("tag internal code wrong");
  chk_dir_cv_code: assert property (@(posedge SYS_CLK) disable iff (RST)
    (DIR_ERR[0].valid && DIR_ERR[0].uncorr && DIR_ERR[0].core_valid &&
     DIR_ERR[0].internal && error_report_control[1] && !dir_valid[0])
    |=> directory_error_status[0][15:0] == 16'h0011)
    else $error("core-valid internal code wrong");
  chk_dir_corr_code: assert property (@(posedge SYS_CLK) disable iff (RST)
    (DIR_ERR[0].valid && !DIR_ERR[0].uncorr && !DIR_ERR[0].core_valid &&
     !DIR_ERR[0].internal && error_report_control[0] && !dir_valid[0])
    |=> directory_error_status[0][15:0] == 16'h0100 && dir_valid[0])
    else $error("corrected external code wrong");
  chk_mc_read_back: assert property (@(posedge SYS_CLK) disable iff (RST)
    (REG_RD && REG_ADDR == umc_pkg::RI_MC_MISC)
    |=> REG_RDATA == $past(transaction_timeout))
    else $error("timeout register read wrong");
  chk_retry_retrain: assert property (@(posedge SYS_CLK) disable iff (RST)
    (MC_CRC_FAIL && !MC_RETRAIN && retry_cnt == 8'(RETRY_LIMIT - 1))
    |=> MC_RETRAIN && retry_cnt == 8'h00)
    else $error("retry limit did not start retraining");
  chk_train_log: assert property (@(posedge SYS_CLK) disable iff (RST)
    (MC_CRC_FAIL && MC_RETRAIN && mc_control_low[umc_pkg::CTL_TRAIN_FAIL] &&
     !mc_status_high[umc_pkg::ST_VALID])
    |=> mc_status_low == umc_pkg::MC_CODE_TRAIN ##2 IRQ.valid == |check_interrupt_mask[DIR_BANKS])
    else $error("training failure not logged");
  chk_irq_raise: assert property (@(posedge SYS_CLK) disable iff (RST)
    |(check_interrupt_pending & check_interrupt_mask)
    |=> IRQ.valid && IRQ.vector == $past(redirect[7:0]))
    else $error("interrupt not raised");
  chk_alloc_block: assert property (@(posedge SYS_CLK) disable iff (RST)
    (line_disable.valid && ALLOC_SET == line_disable.set &&
     ALLOC_WAY == line_disable.way) |-> !ALLOC_GRANT)
    else $error("allocation into disabled line");
  chk_cache_late: assert property (@(posedge SYS_CLK) disable iff (RST)
    CACHE_EN |-> state == ST_RUN && !rd_pend)
    else $error("cache enabled before replay done");
  chk_ring_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    strap_done |-> (RING_ALLOC_EN & core_off) == '0)
    else $error("ring cache allocation on disabled core");
  chk_valid_sticky: assert property (@(posedge SYS_CLK) disable iff (RST)
    (dir_valid[0] && !wr_hit(dir_idx(0, 1'b0))) |=> dir_valid[0] && check_interrupt_pending[0])
    else $error("valid bit dropped without clear");

endmodule : umc_check_log
`default_nettype wire

// [umc_core_model.sv]
// Core model that takes machine-check interrupts from the block.
// Assumes IRQ is a registered level driven by the block.
`timescale 1ns/1ps
`default_nettype none
module umc_core_model (
  input  wire logic              SYS_CLK,
  input  wire umc_pkg::umc_irq_t irq,
  output logic      [15:0]       taken
);
  // Record core and vector while the interrupt level stands
  always_ff @(posedge SYS_CLK) begin
    if (irq.valid) taken <= {irq.core, irq.vector};
  end
endmodule : umc_core_model
`default_nettype wire

// [umc_line_mem.sv]
// Small memory holding the line disable entries.
// Array has no reset so contents survive a reset of the block.
`timescale 1ns/1ps
`default_nettype none
module umc_line_mem #(
  parameter int W     = 21,
  parameter int DEPTH = 16
) (
  input  wire logic                     SYS_CLK,
  input  wire logic                     RST,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [W-1:0]             wr_data,
  input  wire logic                     rd_en,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [W-1:0]             rd_data
);

  logic [W-1:0] mem [DEPTH];

  // Write port
  always_ff @(posedge SYS_CLK) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : umc_line_mem
`default_nettype wire

// [umc_pkg.sv]
// Shared constants and types for the uncore machine-check logging block.
// Assumes a single 100 MHz clock and a word-indexed register port.
package umc_pkg;

  // Register indices on the register port
  localparam logic [4:0] RI_MC_CTL_LO   = 5'h00;
  localparam logic [4:0] RI_MC_CTL_HI   = 5'h01;
  localparam logic [4:0] RI_MC_STAT_LO  = 5'h02;
  localparam logic [4:0] RI_MC_STAT_HI  = 5'h03;
  localparam logic [4:0] RI_MC_ADDR_LO  = 5'h04;
  localparam logic [4:0] RI_MC_ADDR_HI  = 5'h05;
  localparam logic [4:0] RI_MC_MISC     = 5'h06;
  localparam logic [4:0] RI_DIR_CTL     = 5'h08;
  localparam logic [4:0] RI_DIR0_STAT   = 5'h09;
  localparam logic [4:0] RI_PEND        = 5'h10;
  localparam logic [4:0] RI_MASK        = 5'h11;
  localparam logic [4:0] RI_REDIR       = 5'h12;
  localparam logic [4:0] RI_LD_DIR      = 5'h13;
  localparam logic [4:0] RI_LD_WRITE    = 5'h14;
  localparam logic [4:0] RI_SYS_STAT    = 5'h15;

  // Status word fields
  localparam int ST_VALID  = 31;
  localparam int ST_OVER   = 30;
  localparam int ST_UNCORR = 29;

  // Enable bits in the control registers
  localparam int CTL_TAG_STATE  = 0;
  localparam int CTL_CORE_VALID = 1;
  localparam int CTL_RETRY      = 0;
  localparam int CTL_TRAIN_FAIL = 29;

  // Directory model codes
  localparam logic [15:0] DC_TS_UC_EXT = 16'h0001;
  localparam logic [15:0] DC_TS_UC_INT = 16'h0002;
  localparam logic [15:0] DC_CV_UC_EXT = 16'h0010;
  localparam logic [15:0] DC_CV_UC_INT = 16'h0011;
  localparam logic [15:0] DC_TS_C_EXT  = 16'h0100;
  localparam logic [15:0] DC_TS_C_INT  = 16'h0101;
  localparam logic [15:0] DC_CV_C_EXT  = 16'h0110;
  localparam logic [15:0] DC_CV_C_INT  = 16'h0111;

  // Memory controller model codes
  localparam logic [31:0] MC_CODE_RETRY = 32'h0000_0001;
  localparam logic [31:0] MC_CODE_TRAIN = 32'h0200_0000;

  // Redirection, line disable write and system status fields
  localparam int REDIR_VEC_LSB  = 0;
  localparam int REDIR_CORE_LSB = 8;
  localparam int LD_IDX_LSB     = 24;
  localparam int SS_CACHE_EN    = 0;
  localparam int SS_RETRAIN     = 1;
  localparam int SS_CNT_LSB     = 8;
  localparam logic [3:0] DIR_UNIT = 4'h0;

  // Error report from one directory bank
  typedef struct packed {
    logic        valid;
    logic        uncorr;
    logic        core_valid;
    logic        internal;
    logic [31:0] addr;
  } umc_dir_err_t;

  // One line disable entry, also the reset packet payload
  typedef struct packed {
    logic        valid;
    logic [3:0]  unit;
    logic [11:0] set;
    logic [3:0]  way;
  } umc_ld_t;

  localparam int LD_W = $bits(umc_ld_t);

  // Machine-check interrupt to a core
  typedef struct packed {
    logic       valid;
    logic [7:0] core;
    logic [7:0] vector;
  } umc_irq_t;

endpackage : umc_pkg

// [uncore_machine_check_logging_test.sv]
// Self-checking bench for the machine-check logging block.
// Assumes the package, design files and core model compile first.
`timescale 1ns/1ps
`default_nettype none
module uncore_machine_check_logging_test;
  logic                        clk = 0, rst = 1, wr = 0, rd = 0, crc = 0, areq = 0, grant;
  logic                        retr, cen, tf = 0, td = 0, xd = 0;
  logic [4:0]                  ad = 0;
  logic [31:0]                 wd = 0, rq, s = 32'h4bd64008;
  logic [15:0]                 aloc = 0, taken;
  logic [7:0]                  cmask = 0, vis, ren;
  logic [3:0]                  agv = 0;
  umc_pkg::umc_dir_err_t [1:0] de = '0;
  umc_pkg::umc_irq_t           irq;
  umc_pkg::umc_ld_t            pkt, pk;
  int                          fails = 0, checks = 0, cyc = 0;
  localparam logic [15:0] CODES [8] = '{16'h0100, 16'h0101, 16'h0110, 16'h0111,
                                        16'h0001, 16'h0002, 16'h0010, 16'h0011};
  umc_check_log #(.LD_DEPTH(4))
    DUT (.SYS_CLK(clk), .RST(rst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(ad), .REG_WDATA(wd),
    .REG_RDATA(rq), .DIR_ERR(de), .MC_CRC_FAIL(crc), .MC_TRAIN_FAIL(tf),
    .MC_TRAIN_DONE(td), .MC_TXN_DONE(xd), .MC_TXN_ADDR({s, s}), .MC_RETRAIN(retr),
    .AGENT_VALID(agv), .IRQ(irq), .CORE_MASK(cmask), .CORE_VISIBLE(vis),
    .RING_ALLOC_EN(ren), .ALLOC_REQ(areq), .ALLOC_SET(aloc[15:4]), .ALLOC_WAY(aloc[3:0]),
    .ALLOC_GRANT(grant), .PKT(pkt), .CACHE_EN(cen));
  umc_core_model core (.SYS_CLK(clk), .irq(irq), .taken(taken));
  ////////////////////////////////////////
  // Clock, hang limit and reset packet capture
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (pkt.valid) pk <= pkt;
    if (cyc == 5000) begin
      fails++;
      final_report();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  // One register write or read, strobe held over one edge
  task automatic rg(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(negedge clk);
    {wr, rd, ad, wd} = {w, !w, a, d};
    @(negedge clk);
    {wr, rd} = 2'b00;
    @(negedge clk);
  endtask : rg
  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    agv = s[3:0];
    repeat (8) @(negedge clk);
    rg(1, umc_pkg::RI_DIR_CTL, 32'h3);
    rg(1, umc_pkg::RI_MASK, 32'h7);
    rg(1, umc_pkg::RI_REDIR, 32'h0342);
    rg(0, umc_pkg::RI_PEND, 0);
    cmp("pending", {agv, 3'b000}, rq);
    rg(0, 5'h1f, 0);
    cmp("unmapped", 0, rq);
    for (int k = 0; k < 8; k++) begin
      int b;
      b = k[0] ^ k[2];
      s = lfsr(s);
      de[b] = {1'b1, k[2], k[1], k[0], s};
      @(negedge clk);
      de = '0;
      repeat (3) @(negedge clk);
      cmp("irq", 32'h10342, {irq.valid, irq.core, irq.vector});
      cmp("core", 32'h0342, taken);
      rg(0, umc_pkg::RI_DIR0_STAT + 5'(2 * b), 0);
      cmp("dir status", {2'b10, k[2], 13'h0, CODES[k]}, rq);
      rg(0, umc_pkg::RI_DIR0_STAT + 5'(2 * b + 1), 0);
      cmp("dir address", s, rq);
      rg(1, umc_pkg::RI_DIR0_STAT + 5'(2 * b), 0);
    end
    $display("directory test done");
    rg(1, umc_pkg::RI_MC_CTL_LO, 32'h2000_0001);
    repeat (4) rg(1, 5'h1f, 0) ;
    rg(1, umc_pkg::RI_MC_MISC, s);
    rg(0, umc_pkg::RI_MC_MISC, 0);
    cmp("timeout", s, rq);
    for (int i = 0; i < 5; i++) begin
      crc = (i < 4);
      @(negedge clk);
    end
    cmp("retrain", 1, retr);
    rg(0, umc_pkg::RI_MC_STAT_LO, 0);
    cmp("retry code", 1, rq);
    rg(1, umc_pkg::RI_MC_STAT_HI, 0);
    crc = 1;
    @(negedge clk);
    crc = 0;
    rg(0, umc_pkg::RI_MC_STAT_LO, 0);
    cmp("train code", 32'h0200_0000, rq);
    rg(0, umc_pkg::RI_MC_ADDR_HI, 0);
    cmp("mc address", s, rq);
    td = 1;
    @(negedge clk);
    td = 0;
    cmp("retrain done", 0, retr);
    for (int i = 0; i < 5; i++) begin
      {crc, xd} = {i != 3, i == 3};
      @(negedge clk);
    end
    crc = 0;
    cmp("count cleared", 0, retr);
    rg(1, umc_pkg::RI_MC_STAT_HI, 0);
    tf = 1;
    @(negedge clk);
    tf = 0;
    rg(0, umc_pkg::RI_MC_STAT_HI, 0);
    cmp("train status", 32'ha000_0000, rq);
    $display("memory controller test done");
    for (int i = 3; i >= 0; i--) rg(1, umc_pkg::RI_LD_WRITE, {4'h0, 4'(i), 3'h0, i == 0, 4'h0, s[15:0]});
    cmask = s[23:16];
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    repeat (2) @(negedge clk);
    cmp("cache early", 0, cen);
    repeat (6) @(negedge clk);
    cmp("cache enable", 1, cen);
    cmp("packet", {1'b1, 4'h0, s[15:0]}, pk);
    cmp("visible", {~cmask}, vis);
    cmp("ring alloc", {~cmask}, ren);
    {areq, aloc} = {1'b1, s[15:0]};
    @(negedge clk);
    cmp("grant hit", 0, grant);
    aloc[3:0] = ~s[3:0];
    @(negedge clk);
    cmp("grant miss", 1, grant);
    $display("line and core disable test done");
    final_report();
  end
endmodule : uncore_machine_check_logging_test
`default_nettype wire
